// [logic/dpsb_pkg.sv]
// constants, register map and types for the datapath source and blanking block
package dpsb_pkg;
  // register addresses
  localparam logic [11:0] A_TXEN = 12'h03f;
  localparam logic [11:0] A_FSC = 12'h042;
  localparam logic [11:0] A_UPS = 12'h110;
  localparam logic [11:0] A_DPCFG = 12'h111;
  localparam logic [11:0] A_TW_LO = 12'h114;
  localparam logic [11:0] A_TW_HI = 12'h115;
  localparam logic [11:0] A_DC_HI = 12'h14e;
  localparam logic [11:0] A_DC_LO = 12'h14f;
  localparam logic [11:0] A_DCT = 12'h150;
  localparam logic [11:0] A_STAT = 12'h151;
  localparam logic [11:0] A_HOP = 12'h800;
  // transmit-enable control fields
  localparam int TX_PASS_OUT = 7;
  localparam int TX_PASS_IN = 6;
  localparam int TX_NCO_PIN = 3;
  localparam int TX_OUT_PIN = 2;
  localparam int TX_IN_PIN = 1;
  localparam int TX_FSC_PIN = 0;
  localparam logic [7:0] TXEN_WMASK = 8'hcf;
  localparam logic [7:0] TXEN_RST = 8'hc0;
  // other fields
  localparam int DCT_BIT = 1;
  localparam int SINC_BIT = 7;
  localparam int NCO_EN_BIT = 6;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam logic [1:0] MODE_DISC = 2'h1;
  localparam logic [3:0] UPS_BYPASS = 4'h0;
  localparam logic [7:0] FSC_RST = 8'hff;
  localparam logic [7:0] FSC_MIN_DIV = 8'h0a;
  localparam int TW_W = 16;
  // ramp timing: one current step per this time
  localparam int CLK_NS = 8;
  localparam int RAMP_STEP_NS = 64;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_NS - 1) / CLK_NS;
  // seven-tap rolloff compensation, symmetric, scaled by 2^6
  localparam int FIR_TAPS = 7;
  localparam int FIR_SHIFT = 6;
  localparam logic signed [7:0] FIR_COEF [FIR_TAPS] = '{8'shff, 8'sh02, 8'shf6, 8'sh50, 8'shf6, 8'sh02, 8'shff};
  // current ramp states, gray along the usual path
  typedef enum logic [1:0] {
    FSC_FULL = 2'b00,
    FSC_FALL = 2'b01,
    FSC_MIN = 2'b11,
    FSC_RISE = 2'b10
  } dpsb_fsc_t;
endpackage

// [logic/dpsb_sync2.sv]
// two-flop synchroniser for pin levels
`timescale 1ns/1ns
module dpsb_sync2 #(
  parameter int W = 1
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta; // first stage, read only by q_out

  // both stages clear on reset so the pin reads low until sampled
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule

// [logic/dpsb_fifo.sv]
// small first-word-fall-through fifo for link samples
`timescale 1ns/1ns
module dpsb_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic wr_valid_in,
  input wire logic [W-1:0] wr_data_in,
  output logic wr_ready_out,
  output logic rd_valid_out,
  output logic [W-1:0] rd_data_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("fifo depth must be a power of two of at least 2");
    end
  endgenerate
  logic [W-1:0] mem [DEPTH]; // storage
  logic [AW:0] wptr; // write pointer, extra wrap bit
  logic [AW:0] rptr; // read pointer, extra wrap bit
  logic push;
  logic pop;

  // honest flags from pointer compare
  assign wr_ready_out = (wptr ^ rptr) != {1'b1, {AW{1'b0}}};
  assign rd_valid_out = wptr != rptr;
  assign rd_data_out = mem[rptr[AW-1:0]];
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;

  // storage write, no reset needed for data
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= wr_data_in;
    end
  end

  // pointers
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
    end
  end

  a_no_overfill: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !wr_ready_out |=> $stable(wptr) || $past(pop)) else $error("fifo written while full");
endmodule

// [logic/dpsb_datapath_blank.sv]
// datapath source select, rolloff filter, blanking and current ramp
//
// Function
// - constant source select feeds datapath from test word
// - test word sixteen bits, two bytes, resets zero
// - link data received but kept off DAC
// - source select acts immediately, no restart
// - oscillator makes tone without any link
// - seven-tap rolloff filter only when enabled
// - link faults force zeros toward DAC unless constant source selected
// - control bit seven zeroes or passes output
// - control bit six zeroes or passes input
// - bit three picks oscillator reset source
// - bit two picks output zeroing source
// - bit one picks input zeroing source
// - bit zero picks current control source
// - pin ramps current down and back up
// - input zeroing ramps; bypass drops at once
// - change mode decides if reset happens
// - mode one clears phase on tuning update
`timescale 1ns/1ns
module dpsb_datapath_blank import dpsb_pkg::*; #(
  parameter int DW = 16,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic reg_wr_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic link_valid_in,
  input wire logic [DW-1:0] link_data_in,
  output logic link_ready_out,
  input wire logic link_fault_in,
  input wire logic tx_enable_pin_in,
  input wire logic dac_ready_in,
  output logic [DW-1:0] dac_data_out,
  output logic [7:0] dac_fsc_out
);
  generate
    if (DW != 16) begin : g_bad_dw
      $error("data width must be 16, matching the two test word bytes");
    end
  endgenerate

  localparam int AW = DW + 8; // filter accumulator width

  logic [7:0] txen; // transmit-enable control
  logic [7:0] fsc_set; // programmed full-scale current
  logic [3:0] ups_sel; // upsample_ratio_select
  logic rolloff_comp_filter_on; // filter insert
  logic nco_en; // oscillator enable
  logic [DW-1:0] dc_word; // constant test word
  logic constant_source_select; // test word replaces link
  logic [1:0] hop_mode; // frequency change mode
  logic [7:0] tw_stage; // low tuning byte waits for high
  logic [TW_W-1:0] tuning_word; // active tuning word
  logic tw_upd; // one-cycle tuning update
  logic [TW_W-1:0] phase; // phase accumulator
  logic pin_s; // synchronised pin
  logic pin_q; // pin delayed for edges
  logic pin_rise;
  logic pass_in; // data may enter datapath
  logic pass_out; // data may reach DAC
  logic blank_out;
  logic nco_clear;
  logic fifo_valid;
  logic [DW-1:0] fifo_data;
  logic fifo_take;
  logic fifo_rd_ready;
  logic [DW-1:0] tone; // oscillator output
  logic [DW-1:0] src; // selected source sample
  logic [DW-1:0] s0; // datapath input stage
  logic [DW-1:0] taps [FIR_TAPS]; // filter delay line
  logic signed [AW-1:0] acc; // filter sum
  logic [DW-1:0] s1; // after rolloff filter
  logic [DW-1:0] smooth; // interpolation stand-in state
  logic [DW-1:0] next_smooth;
  logic [DW:0] avg_sum;
  dpsb_fsc_t fsc_state;
  dpsb_fsc_t next_fsc_state;
  logic [7:0] fsc_cur; // current code being driven
  logic [7:0] fsc_min; // floor of the ramp, about -20 dB
  logic [$clog2(RAMP_STEP_CYC+1)-1:0] step_cnt;
  logic step_tick;
  logic [7:0] next_rdata;

  // register write strobe for one address
  function automatic logic hit(input logic [11:0] a);
    return reg_wr_in && (reg_addr_in == a);
  endfunction

  // clamp a filter sum back to sample width
  function automatic logic [DW-1:0] sat(input logic signed [AW-1:0] v);
    logic signed [AW-1:0] hi;
    logic signed [AW-1:0] lo;
    hi = AW'({1'b0, {(DW-1){1'b1}}});
    lo = ~hi;
    if (v > hi) begin
      return {1'b0, {(DW-1){1'b1}}};
    end else if (v < lo) begin
      return {1'b1, {(DW-1){1'b0}}};
    end
    return v[DW-1:0];
  endfunction

  // pin is asynchronous to this clock
  dpsb_sync2 #(.W(1)) u_pin_sync (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .d_in(tx_enable_pin_in),
    .q_out(pin_s)
  );

  // link samples buffer; back-pressure reaches the link
  dpsb_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .wr_valid_in(link_valid_in),
    .wr_data_in(link_data_in),
    .wr_ready_out(link_ready_out),
    .rd_valid_out(fifo_valid),
    .rd_data_out(fifo_data),
    .rd_ready_in(fifo_rd_ready)
  );

  // transmit-enable control, reserved bits held zero
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      txen <= TXEN_RST;
    end else if (hit(A_TXEN)) begin
      txen <= reg_wdata_in & TXEN_WMASK;
    end
  end

  // datapath configuration registers
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      fsc_set <= FSC_RST;
      ups_sel <= UPS_BYPASS;
      rolloff_comp_filter_on <= 1'b0;
      nco_en <= 1'b0;
      hop_mode <= '0;
    end else begin
      if (hit(A_FSC)) begin
        fsc_set <= reg_wdata_in;
      end
      if (hit(A_UPS)) begin
        ups_sel <= reg_wdata_in[3:0];
      end
      if (hit(A_DPCFG)) begin
        rolloff_comp_filter_on <= reg_wdata_in[SINC_BIT];
        nco_en <= reg_wdata_in[NCO_EN_BIT];
      end
      if (hit(A_HOP)) begin
        hop_mode <= reg_wdata_in[MODE_HI:MODE_LO];
      end
    end
  end

  // test word bytes and source select; select acts next cycle
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      dc_word <= '0;
      constant_source_select <= 1'b0;
    end else begin
      if (hit(A_DC_HI)) begin
        dc_word[DW-1:8] <= reg_wdata_in;
      end
      if (hit(A_DC_LO)) begin
        dc_word[7:0] <= reg_wdata_in;
      end
      if (hit(A_DCT)) begin
        constant_source_select <= reg_wdata_in[DCT_BIT];
      end
    end
  end

  // tuning word: low byte staged, high byte write commits both
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      tw_stage <= '0;
      tuning_word <= '0;
      tw_upd <= 1'b0;
    end else begin
      tw_upd <= hit(A_TW_HI);
      if (hit(A_TW_LO)) begin
        tw_stage <= reg_wdata_in;
      end
      if (hit(A_TW_HI)) begin
        tuning_word <= {reg_wdata_in, tw_stage};
      end
    end
  end

  // pin edge for oscillator reset
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_s;
    end
  end

  assign pin_rise = pin_s && !pin_q;
  // reset source picked by bit three, honoured only in mode one
  assign nco_clear = (hop_mode == MODE_DISC) && (txen[TX_NCO_PIN] ? pin_rise : tw_upd);
  assign pass_in = txen[TX_IN_PIN] ? pin_s : txen[TX_PASS_IN];
  assign pass_out = txen[TX_OUT_PIN] ? pin_s : txen[TX_PASS_OUT];
  // link faults only matter while the link feeds the datapath
  assign blank_out = !pass_out || (!constant_source_select && link_fault_in);

  // phase accumulator, runs with no link at all
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in || !nco_en) begin
      phase <= '0;
    end else if (nco_clear) begin
      phase <= '0;
    end else begin
      phase <= phase + tuning_word;
    end
  end

  // tone is the test word with its sign flipped each half cycle
  assign tone = phase[TW_W-1] ? DW'(-dc_word) : dc_word;
  // in constant mode the fifo is drained and dropped so the link never stalls
  assign fifo_rd_ready = constant_source_select || dac_ready_in;
  assign fifo_take = fifo_valid && fifo_rd_ready;
  // underrun or a stalled DAC inserts zero rather than stale data
  assign src = constant_source_select ? (nco_en ? tone : dc_word) :
               (fifo_take ? fifo_data : '0);

  // datapath input stage with input zeroing
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      s0 <= '0;
    end else begin
      s0 <= pass_in ? src : '0;
    end
  end

  // filter delay line
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < FIR_TAPS; i++) begin
        taps[i] <= '0;
      end
    end else begin
      taps[0] <= s0;
      for (int i = 1; i < FIR_TAPS; i++) begin
        taps[i] <= taps[i-1];
      end
    end
  end

  // filter sum; center tap is taps[3], three cycles of group delay
  always_comb begin
    acc = '0;
    for (int i = 0; i < FIR_TAPS; i++) begin
      acc = acc + AW'(signed'(taps[i]) * FIR_COEF[i]);
    end
  end

  // filter inserted only on request, else straight through
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      s1 <= '0;
    end else begin
      s1 <= rolloff_comp_filter_on ? sat(acc >>> FIR_SHIFT) : s0;
    end
  end

  // outside bypass a simple averager stands in for the upsample
  // filters so that a zeroed input decays instead of stepping
  assign avg_sum = {s1[DW-1], s1} + {smooth[DW-1], smooth};
  assign next_smooth = (ups_sel == UPS_BYPASS) ? s1 : avg_sum[DW:1];

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      smooth <= '0;
    end else begin
      smooth <= next_smooth;
    end
  end

  // final blanking mux toward the DAC decoder
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      dac_data_out <= '0;
    end else begin
      dac_data_out <= blank_out ? '0 : next_smooth;
    end
  end

  // ramp pacing counter
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in || step_tick) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= step_cnt + 1'b1;
    end
  end

  assign step_tick = step_cnt == ($bits(step_cnt))'(RAMP_STEP_CYC - 1);
  // tenfold current drop is about 20 dB
  assign fsc_min = fsc_set / FSC_MIN_DIV;

  // current ramp sequencing
  always_comb begin
    next_fsc_state = fsc_state;
    unique case (fsc_state)
      FSC_FULL: begin
        if (txen[TX_FSC_PIN] && !pin_s) begin
          next_fsc_state = FSC_FALL;
        end
      end
      FSC_FALL: begin
        if (!txen[TX_FSC_PIN] || pin_s) begin
          next_fsc_state = FSC_RISE;
        end else if (fsc_cur <= fsc_min) begin
          next_fsc_state = FSC_MIN;
        end
      end
      FSC_MIN: begin
        if (!txen[TX_FSC_PIN] || pin_s) begin
          next_fsc_state = FSC_RISE;
        end
      end
      FSC_RISE: begin
        if (txen[TX_FSC_PIN] && !pin_s) begin
          next_fsc_state = FSC_FALL;
        end else if (fsc_cur >= fsc_set) begin
          next_fsc_state = FSC_FULL;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      fsc_state <= FSC_FULL;
    end else begin
      fsc_state <= next_fsc_state;
    end
  end

  // current code: follows register when idle, steps while ramping
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      fsc_cur <= FSC_RST;
    end else if (fsc_state == FSC_FULL) begin
      fsc_cur <= fsc_set;
    end else if (step_tick && fsc_state == FSC_FALL && fsc_cur > fsc_min) begin
      fsc_cur <= fsc_cur - 8'h01;
    end else if (step_tick && fsc_state == FSC_RISE && fsc_cur < fsc_set) begin
      fsc_cur <= fsc_cur + 8'h01;
    end
  end

  assign dac_fsc_out = fsc_cur;

  // readback, one cycle after the address; unmapped reads zero
  always_comb begin
    unique case (reg_addr_in)
      A_TXEN: next_rdata = txen;
      A_FSC: next_rdata = fsc_set;
      A_UPS: next_rdata = {4'h0, ups_sel};
      A_DPCFG: next_rdata = {rolloff_comp_filter_on, nco_en, 6'h00};
      A_TW_LO: next_rdata = tuning_word[7:0];
      A_TW_HI: next_rdata = tuning_word[TW_W-1:8];
      A_DC_HI: next_rdata = dc_word[DW-1:8];
      A_DC_LO: next_rdata = dc_word[7:0];
      A_DCT: next_rdata = {6'h00, constant_source_select, 1'b0};
      A_STAT: next_rdata = {5'h00, fsc_state != FSC_FULL, blank_out, pin_s};
      A_HOP: next_rdata = {hop_mode, 6'h00};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  a_const_source: assert property (constant_source_select && !nco_en && pass_in |=> s0 == $past(dc_word))
    else $error("test word not at datapath input");
  a_dc_reset: assert property (@(posedge core_clk_in) disable iff (1'b0)
    !rstn_in |=> dc_word == '0 && !rolloff_comp_filter_on)
    else $error("test word or filter enable not cleared by reset");
  a_link_drained: assert property (constant_source_select && fifo_valid |-> fifo_take)
    else $error("link samples not drained in constant mode");
  a_select_live: assert property (hit(A_DCT) |=> constant_source_select == $past(reg_wdata_in[DCT_BIT]))
    else $error("source select did not follow write");
  a_sinc_bypass: assert property (!rolloff_comp_filter_on |=> s1 == $past(s0))
    else $error("filter active while disabled");
  a_fault_blank: assert property (!constant_source_select && link_fault_in |=> dac_data_out == '0)
    else $error("link fault did not blank output");
  a_out_zero: assert property (!txen[TX_OUT_PIN] && !txen[TX_PASS_OUT] |=> dac_data_out == '0)
    else $error("output not zeroed by control bit");
  a_in_zero: assert property (!txen[TX_IN_PIN] && !txen[TX_PASS_IN] |=> s0 == '0)
    else $error("input not zeroed by control bit");
  a_pin_blank: assert property ((txen[TX_OUT_PIN] && !tx_enable_pin_in)[*2] ##1 txen[TX_OUT_PIN]
    |=> dac_data_out == '0)
    else $error("pin low did not blank output");
  a_phase_clear: assert property (nco_en && hop_mode == MODE_DISC && !txen[TX_NCO_PIN] && tw_upd
    |=> phase == '0)
    else $error("phase not cleared on tuning update");
  a_phase_keep: assert property (nco_en && hop_mode != MODE_DISC |=> phase == $past(phase) + $past(tuning_word))
    else $error("phase disturbed outside mode one");
  a_fsc_floor: assert property (fsc_state == FSC_MIN |-> fsc_cur <= fsc_min)
    else $error("current above floor at ramp bottom");
  a_fsc_regs: assert property (fsc_state == FSC_FULL |=> dac_fsc_out == $past(fsc_set))
    else $error("current not following register");
endmodule

// [tb/dpsb_link_src.sv]
// link sample source model for the datapath blanking bench
`timescale 1ns/1ns
module dpsb_link_src (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic en_in,
  input wire logic slow_in,
  input wire logic [15:0] value_in,
  input wire logic ready_in,
  output logic valid_out,
  output logic [15:0] data_out
);
  logic gap; // idle slot already spent in slow mode
  // offer one word, hold it until taken; slow mode idles a cycle between words
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      valid_out <= 1'b0;
      data_out <= 16'h0000;
      gap <= 1'b0;
    end else if (valid_out && !ready_in) begin
      // request stays unchanged until accepted
    end else if (en_in && !(slow_in && !gap)) begin
      valid_out <= 1'b1;
      data_out <= value_in;
      gap <= 1'b0;
    end else begin
      // nothing offered: data toggles so a stale word never looks valid
      valid_out <= 1'b0;
      data_out <= ~data_out;
      gap <= 1'b1;
    end
  end
endmodule

// [tb/dpsb_datapath_blank_test.sv]
// self-checking bench for the datapath source and blanking block
`timescale 1ns/1ns
module dpsb_datapath_blank_test;
  import dpsb_pkg::*;
  logic clk = 1'b0; // 125 MHz core clock
  logic rstn = 1'b0; // active low reset
  logic wr = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic lvalid;
  logic [15:0] ldata;
  logic lready;
  logic fault = 1'b0;
  logic pin = 1'b1;
  logic dready = 1'b1;
  logic [15:0] dac;
  logic [7:0] fsc;
  logic src_en = 1'b0; // partner offers words
  logic src_slow = 1'b0; // partner idles between words
  logic [15:0] a; // scratch sample
  int errors = 0;
  int n_tests = 0;

  // clock: half period 4 ns
  always #4 clk = ~clk;

  dpsb_datapath_blank uut (.core_clk_in(clk), .rstn_in(rstn), .reg_wr_in(wr), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .link_valid_in(lvalid), .link_data_in(ldata),
    .link_ready_out(lready), .link_fault_in(fault), .tx_enable_pin_in(pin), .dac_ready_in(dready),
    .dac_data_out(dac), .dac_fsc_out(fsc));

  dpsb_link_src src (.core_clk_in(clk), .rstn_in(rstn), .en_in(src_en), .slow_in(src_slow),
    .value_in(16'h1234), .ready_in(lready), .valid_out(lvalid), .data_out(ldata));

  // compare seen against expected and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // wait n edges then let updates settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one register write, strobe high for one cycle
  task automatic wreg(input logic [11:0] ad, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= ad;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // register read: data registered one edge after the address
  task automatic rreg(input logic [11:0] ad, output logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    cyc(2);
    d = rdata;
  endtask

  // verdict, single exit of the run
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // reset values, reserved bits, unmapped address
  task automatic t_regs;
    logic [7:0] d;
    rreg(A_TXEN, d); check({8'h00, d}, 16'h00c0);
    rreg(A_DC_HI, d); check({8'h00, d}, 16'h0000);
    rreg(A_DC_LO, d); check({8'h00, d}, 16'h0000);
    rreg(12'h3ff, d); check({8'h00, d}, 16'h0000);
    wreg(A_TXEN, 8'hff);
    rreg(A_TXEN, d); check({8'h00, d}, 16'h00cf);
    wreg(A_TXEN, 8'hc0);
    $display("test regs done");
  endtask

  // link source, fault blanking, register and pin blanking
  task automatic t_blank;
    src_en <= 1'b1;
    cyc(10); check(dac, 16'h1234);
    fault <= 1'b1;
    cyc(1); check(dac, 16'h0000);
    fault <= 1'b0;
    wreg(A_TXEN, 8'h40); cyc(2); check(dac, 16'h0000);
    wreg(A_TXEN, 8'h80); cyc(3); check(dac, 16'h0000);
    wreg(A_TXEN, 8'hc4); pin <= 1'b0; cyc(6); check(dac, 16'h0000);
    pin <= 1'b1; cyc(6); check(dac, 16'h1234);
    wreg(A_TXEN, 8'h82); pin <= 1'b0; cyc(7); check(dac, 16'h0000);
    pin <= 1'b1; cyc(7); check(dac, 16'h1234);
    // outside bypass a zeroed input halves each cycle instead of stepping
    wreg(A_UPS, 8'h01);
    wreg(A_TXEN, 8'h80); cyc(3); check(dac, 16'h091a);
    cyc(1); check(dac, 16'h048d);
    wreg(A_UPS, 8'h00);
    wreg(A_TXEN, 8'hc0);
    $display("test blank done");
  endtask

  // constant source on the fly, rolloff filter, oscillator tone
  task automatic t_const;
    wreg(A_UPS, 8'h00);
    wreg(A_DC_HI, 8'h10);
    wreg(A_DC_LO, 8'h00);
    wreg(A_DCT, 8'h02); cyc(6); check(dac, 16'h1000);
    wreg(A_DPCFG, 8'h80); cyc(16); check(dac, 16'h0f80);
    wreg(A_DPCFG, 8'h00); cyc(12); check(dac, 16'h1000);
    src_en <= 1'b0;
    wreg(A_TW_LO, 8'h00);
    wreg(A_TW_HI, 8'h80);
    wreg(A_DPCFG, 8'h40); cyc(6);
    a = dac;
    cyc(1); check(a + dac, 16'h0000);
    check(a | dac, 16'hf000);
    wreg(A_DPCFG, 8'h00);
    wreg(A_DCT, 8'h00);
    $display("test const done");
  endtask

  // mode one: phase clears on tuning update, then on pin rise when bit three picks the pin
  task automatic t_hop;
    wreg(A_UPS, 8'h00);
    wreg(A_DCT, 8'h02);
    wreg(A_HOP, 8'h40);
    wreg(A_DPCFG, 8'h40);
    wreg(A_TW_LO, 8'h00);
    wreg(A_TW_HI, 8'h40);
    // without the clear the sign pattern would be one step earlier
    cyc(5); check(dac, 16'h1000);
    cyc(1); check(dac, 16'hf000);
    wreg(A_TXEN, 8'hc8);
    pin <= 1'b0;
    cyc(3);
    pin <= 1'b1;
    cyc(7); check(dac, 16'h1000);
    cyc(1); check(dac, 16'hf000);
    wreg(A_HOP, 8'h00);
    wreg(A_DPCFG, 8'h00);
    wreg(A_DCT, 8'h00);
    wreg(A_TXEN, 8'hc0);
    $display("test hop done");
  endtask

  // fifo fills while the converter stalls, drains with the source off, then keeps up with a slow source
  task automatic t_fifo;
    dready <= 1'b0;
    src_en <= 1'b1;
    cyc(14); check({15'h0000, lready}, 16'h0000);
    check(dac, 16'h0000);
    src_en <= 1'b0;
    src_slow <= 1'b1;
    dready <= 1'b1;
    cyc(14); check({15'h0000, lready}, 16'h0001);
    src_en <= 1'b1;
    cyc(10); check({15'h0000, lready}, 16'h0001);
    $display("test fifo done");
  endtask

  // pin controlled full-scale current ramp: down to a tenth, back up
  task automatic t_fsc;
    logic [7:0] d;
    wreg(A_FSC, 8'h80); cyc(1); check({8'h00, fsc}, 16'h0080);
    wreg(A_FSC, 8'hff);
    wreg(A_TXEN, 8'hc1);
    pin <= 1'b0;
    cyc(2000); check({8'h00, fsc}, 16'h0019);
    rreg(A_STAT, d); check({8'h00, d}, 16'h0004);
    pin <= 1'b1;
    cyc(2000); check({8'h00, fsc}, 16'h00ff);
    rreg(A_STAT, d); check({8'h00, d}, 16'h0001);
    $display("test fsc done");
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_blank();
    t_const();
    t_hop();
    t_fifo();
    t_fsc();
    test_done();
  end

  // watchdog: whole sequence needs well under 8000 cycles
  initial begin
    #64000;
    errors++;
    test_done();
  end
endmodule
